// *** rtl/fepc_ctrl.sv ***
/*
  fepc_ctrl: access gate and erase sequencer in front of program flash.
  assumes: requester holds req_valid_i until req_ready_o; one request at
  a time; protection table arrives as a flat vector from system logic.
*/
// Operation
// - flash array holds 128 KB.
// - erase works on single 1 KB units, others untouched.
// - erased unit reads back all ones.
// - protection granularity is 2 KB, two units per setting.
// - each region is unprotected, read-only or execute-only.
// - read-only region refuses erase and program.
// - execute-only region refuses erase and program.
// - execute-only region returns data only to instruction fetch.
// - data and debug reads of execute-only region are denied.
`timescale 1ns/1ns
module fepc_ctrl
#(
  parameter int NUM_REGIONS = fepc_pkg::NUM_REGIONS
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire fepc_pkg::fepc_req_s req_i,
  input wire logic [2*NUM_REGIONS-1:0] prot_i,
  input wire logic viol_clear_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output fepc_pkg::fepc_rsp_s rsp_o,
  output logic viol_o,
  output logic busy_o
);

  localparam int WAW = fepc_pkg::WORD_AW;
  localparam int OW = fepc_pkg::OFS_W;
  localparam logic [OW-1:0] LAST_OFS = OW'(fepc_pkg::UNIT_WORDS - 1);

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_ERASE,
    ST_DONE
  } fepc_state_e;

  // 32 K words; flash cells modelled as an array cleared by erase
  logic [31:0] mem_r [0:(1 << WAW)-1];
  fepc_state_e state_r;
  logic [fepc_pkg::UNIT_W-1:0] unit_r;
  logic [OW-1:0] ofs_r;
  logic [fepc_pkg::REGION_W-1:0] region;
  logic [NUM_REGIONS-1:0] mod_lock;
  logic [NUM_REGIONS-1:0] fetch_only;
  logic is_fetch;
  logic is_read;
  logic is_mod;
  logic deny;
  logic [WAW-1:0] waddr;
  logic take;
  logic start_erase;
  logic start_prog;
  logic answer;

  assign region = req_i.addr[fepc_pkg::ADDR_W-1:fepc_pkg::REGION_LSB];
  assign is_fetch = req_i.src == fepc_pkg::SRC_FETCH;
  assign is_read = req_i.src == fepc_pkg::SRC_DATA ||
                   req_i.src == fepc_pkg::SRC_DEBUG;
  assign is_mod = req_i.src == fepc_pkg::SRC_PROG ||
                  req_i.src == fepc_pkg::SRC_ERASE;
  assign waddr = req_i.addr[fepc_pkg::ADDR_W-1:2];
  assign take = req_valid_i && state_r == ST_IDLE && !req_ready_o;
  assign start_erase = take && !deny && req_i.src == fepc_pkg::SRC_ERASE;
  assign start_prog = take && !deny && req_i.src == fepc_pkg::SRC_PROG;
  // every take except an accepted erase is answered on the next edge
  assign answer = (take && !start_erase) || state_r == ST_DONE;

  // per-region decode, so the lookup below is a single bit select
  for (genvar g = 0; g < NUM_REGIONS; g++)
  begin : g_region
    fepc_pkg::fepc_prot_e setting;
    assign setting = fepc_pkg::fepc_prot_e'(prot_i[2*g +: 2]);
    // the unused code 3 locks a pair as firmly as a real marking
    assign mod_lock[g] = setting != fepc_pkg::PROT_NONE;
    assign fetch_only[g] = setting == fepc_pkg::PROT_XO;
  end

  always_comb
  begin
    deny = 1'b0;
    // fetch is never refused, whatever the marking
    if (is_mod && mod_lock[region])
    begin
      deny = 1'b1;
    end
    else if (is_read && fetch_only[region])
    begin
      deny = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= ST_IDLE;
      unit_r <= '0;
      ofs_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_erase)
          begin
            unit_r <= req_i.addr[fepc_pkg::ADDR_W-1:fepc_pkg::UNIT_LSB];
            ofs_r <= '0;
            state_r <= ST_ERASE;
          end
        end
        ST_ERASE:
        begin
          // one word per cycle; other requests wait meanwhile
          ofs_r <= ofs_r + 1'b1;
          if (ofs_r == LAST_OFS)
          begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          // spare cycle so the erase answer comes from a flop
          state_r <= ST_IDLE;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // array has no reset: contents persist like flash cells
  always_ff @(posedge clk_i)
  begin
    if (state_r == ST_ERASE)
    begin
      mem_r[{unit_r, ofs_r}] <= fepc_pkg::ERASED_WORD;
    end
    else if (start_prog)
    begin
      // programming only clears bits, as flash cells do
      mem_r[waddr] <= mem_r[waddr] & req_i.wdata;
    end
  end

  // handshake pulses last one cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
    end
    else
    begin
      req_ready_o <= answer;
      rsp_valid_o <= answer;
    end
  end

  // payload holds until the next answer replaces it
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rsp_o <= '0;
    end
    else if (state_r == ST_DONE)
    begin
      rsp_o <= '{ok: 1'b1, denied: 1'b0, rdata: '0};
    end
    else if (answer)
    begin
      rsp_o.ok <= !deny;
      rsp_o.denied <= deny;
      // fetch always served, including execute-only regions
      rsp_o.rdata <= (!deny && (is_fetch || is_read)) ?
                     mem_r[waddr] : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      viol_o <= 1'b0;
    end
    else if (take && deny)
    begin
      viol_o <= 1'b1;
    end
    else if (viol_clear_i)
    begin
      viol_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_o <= 1'b0;
    end
    else
    begin
      busy_o <= start_erase || state_r == ST_ERASE;
    end
  end

endmodule

// *** rtl/fepc_pkg.sv ***
/*
  fepc_pkg: constants and carrier types for the flash erase and protect
  controller.
  assumes: single 10 MHz clock domain, no software register bus.
*/
package fepc_pkg;

  localparam int FLASH_BYTES = 131072;
  localparam int UNIT_BYTES = 1024;
  localparam int REGION_BYTES = 2048;
  localparam int WORD_BYTES = 4;
  localparam int ADDR_W = $clog2(FLASH_BYTES);
  localparam int WORD_AW = ADDR_W - $clog2(WORD_BYTES);
  localparam int NUM_UNITS = FLASH_BYTES / UNIT_BYTES;
  localparam int NUM_REGIONS = FLASH_BYTES / REGION_BYTES;
  localparam int UNIT_WORDS = UNIT_BYTES / WORD_BYTES;
  localparam int UNIT_W = $clog2(NUM_UNITS);
  localparam int REGION_W = $clog2(NUM_REGIONS);
  localparam int OFS_W = $clog2(UNIT_WORDS);
  localparam int UNIT_LSB = $clog2(UNIT_BYTES);
  localparam int REGION_LSB = $clog2(REGION_BYTES);
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

  typedef enum logic [1:0]
  {
    PROT_NONE = 2'h0,
    PROT_RO = 2'h1,
    PROT_XO = 2'h2
  } fepc_prot_e;

  typedef enum logic [2:0]
  {
    SRC_FETCH = 3'h0,
    SRC_DATA = 3'h1,
    SRC_DEBUG = 3'h2,
    SRC_PROG = 3'h3,
    SRC_ERASE = 3'h4
  } fepc_src_e;

  typedef struct packed
  {
    fepc_src_e src;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } fepc_req_s;

  typedef struct packed
  {
    logic ok;
    logic denied;
    logic [31:0] rdata;
  } fepc_rsp_s;

endpackage

// *** tb/fepc_asserts.sv ***
/* fepc_asserts: port checks on fepc_ctrl.
   assumes: bound to every fepc_ctrl, one clock. */
`timescale 1ns/1ns
module fepc_asserts
#(parameter int NUM_REGIONS = 64)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire fepc_pkg::fepc_req_s req_i,
  input wire logic [2*NUM_REGIONS-1:0] prot_i,
  input wire logic viol_clear_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire fepc_pkg::fepc_rsp_s rsp_o,
  input wire logic viol_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic t;
  logic [2:0] s;
  logic [1:0] p;
  // a ready pulse or a running erase means the request is not taken
  assign t = req_valid_i && !req_ready_o && !busy_o;
  assign s = req_i.src;
  assign p = prot_i[2*req_i.addr[16:11] +: 2];
  property p_ro; t && s > 3'h2 && p == 2'h1 |=> rsp_o.denied; endproperty
  a_ro: assert property (p_ro) else $error("ro");
  property p_xo; t && s > 3'h2 && p == 2'h2 |=> rsp_o.denied; endproperty
  a_xo: assert property (p_xo) else $error("xo");
  property p_xr; t && (s == 3'h1 || s == 3'h2) && p == 2'h2
    |=> rsp_o.denied && rsp_o.rdata == 32'h0; endproperty
  a_xr: assert property (p_xr) else $error("xr");
  property p_fx; t && s == 3'h0 |=> rsp_valid_o && rsp_o.ok; endproperty
  a_fx: assert property (p_fx) else $error("fx");
  property p_er; t && s == 3'h4 && p == 2'h0
    |=> busy_o [*8] ##250 rsp_valid_o && rsp_o.ok && !busy_o; endproperty
  a_er: assert property (p_er) else $error("er");
  property p_vi; rsp_valid_o && rsp_o.denied |-> ##[0:1] viol_o; endproperty
  a_vi: assert property (p_vi) else $error("vi");
  property p_vs; viol_o && !viol_clear_i |=> viol_o; endproperty
  a_vs: assert property (p_vs) else $error("vs");
  property p_ex; rsp_valid_o |-> rsp_o.ok ^ rsp_o.denied; endproperty
  a_ex: assert property (p_ex) else $error("ex");
endmodule
bind fepc_ctrl fepc_asserts #(.NUM_REGIONS(NUM_REGIONS)) u_chk (.*);

// *** tb/fepc_host.sv ***
/* fepc_host: requester for fetch, data, debug and modify.
   assumes: each request answered by a ready pulse. */
`timescale 1ns/1ns
module fepc_host
(
  input wire logic clk_i,
  input wire logic req_ready_i,
  input wire fepc_pkg::fepc_rsp_s rsp_i,
  output logic req_valid_o = 0,
  output fepc_pkg::fepc_req_s req_o = 0
);
  task issue(logic [2:0] s, logic [16:0] a,
    output fepc_pkg::fepc_rsp_s r);
    int n;
    n = 0;
    @(posedge clk_i);
    #1 req_o = {s, a, 32'h0};
    req_valid_o = 1;
    while (!req_ready_i && n < 400)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    // a request that never sees ready comes back unknown, never as a pass
    if (n < 400)
      r = rsp_i;
    else
      r = 'x;
    @(posedge clk_i);
    #1 req_valid_o = 0;
    // released lines must not keep the old request
    req_o = ~req_o;
  endtask
endmodule

// *** tb/flash_erase_protect_ctrl_bench.sv ***
/* bench: directed tests of fepc_ctrl.
   assumes: fepc_host drives the request port. */
`timescale 1ns/1ns
module flash_erase_protect_ctrl_bench;
  localparam logic [33:0] OK = 34'h2_0000_0000;
  localparam logic [33:0] NO = 34'h1_0000_0000;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic [127:0] prot_i = 0;
  logic viol_clear_i = 0;
  logic req_valid_i, req_ready_o, rsp_valid_o, viol_o, busy_o;
  fepc_pkg::fepc_req_s req_i;
  fepc_pkg::fepc_rsp_s rsp_o, r;
  int fail_count = 0, checks = 0;
  int rsp_n = 0, busy_n = 0;
  initial forever #50 clk_i = ~clk_i;
  // counts answer pulses and the busy cycles of an erase
  always @(posedge clk_i)
    if (reset_n_i)
    begin
      rsp_n <= rsp_n + int'(rsp_valid_o);
      busy_n <= busy_n + int'(busy_o);
    end
  fepc_ctrl DUT (.*);
  fepc_host u_host (.clk_i, .req_ready_i(req_ready_o), .rsp_i(rsp_o),
    .req_valid_o(req_valid_i), .req_o(req_i));
  task chk(string n, logic [33:0] s, logic [33:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task op(logic [2:0] s, logic [16:0] a, logic [33:0] e);
    int n;
    n = rsp_n;
    u_host.issue(s, a, r);
    chk("rsp", {r.ok, r.denied, r.rdata}, e);
    chk("rsp_valid", 34'(rsp_n - n), 34'h1);
  endtask
  task results;
    $display("checks %0d failures %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task t_erase;
    op(3'h3, 17'h1_F800, OK);
    op(3'h4, 17'h1_FC00, OK);
    chk("busy", 34'(busy_n), 34'(fepc_pkg::UNIT_WORDS + 1));
    op(3'h1, 17'h1_FFFC, 34'h2_FFFF_FFFF);
    op(3'h1, 17'h1_F800, OK);
    $display("erase done");
  endtask
  task t_prot;
    chk("viol", {33'h0, viol_o}, 34'h0);
    op(3'h3, 17'h0_0800, OK);
    op(3'h3, 17'h0_1000, OK);
    prot_i[5:2] = 4'h9;
    op(3'h4, 17'h0_0800, NO);
    op(3'h3, 17'h0_0C00, NO);
    op(3'h1, 17'h0_0800, OK);
    for (int i = 1; i < 5; i++)
      op(i[2:0], 17'h0_1000, NO);
    op(3'h0, 17'h0_1000, OK);
    chk("busy", 34'(busy_n), 34'(fepc_pkg::UNIT_WORDS + 1));
    chk("viol", {33'h0, viol_o}, 34'h1);
    viol_clear_i = 1;
    @(posedge clk_i);
    #1 viol_clear_i = 0;
    chk("viol", {33'h0, viol_o}, 34'h0);
    $display("prot done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    #1 reset_n_i = 1;
    t_erase;
    t_prot;
    results;
  end
  initial
  begin
    #300000 fail_count++;
    results;
  end
endmodule
